// ==== core/sdram_command_burst_core.sv ====
// command decode, bank state, burst engine and power states of the sdram
`timescale 1ns/1ps
module sdram_command_burst_core import sdram_pkg::*; (
	input wire logic clock, // system clock
	input wire logic rst, // async reset, high
	input wire logic cke, // clock enable pin
	input wire cmd_pins_t cmdPins, // chip select and strobes, low active
	input wire logic [1:0] bankSelect, // bank select pins
	input wire logic [ROW_W-1:0] addr, // address pins
	input wire logic lowerByteMask, // mask for bits 7..0
	input wire logic upperByteMask, // mask for bits 15..8
	input wire logic [DATA_W-1:0] dqIn, // data pins in
	output logic [DATA_W-1:0] dqOut, // data pins out
	output logic [1:0] dqOe, // per byte drive enable
	output array_addr_t arrayRdAddr, // array read address
	input wire logic [DATA_W-1:0] arrayRdData, // array read data, same cycle
	output logic arrayWrValid, // queued write word ready
	output write_item_t arrayWrItem, // queued write word
	input wire logic arrayWrReady, // array takes write word
	output logic writeQueueReady, // queue has room
	output logic refreshPulse, // one row refreshed
	output logic [ROW_W-1:0] refreshRow, // internal refresh counter
	output logic [BANKS-1:0] bankActive, // open banks
	output logic poweredDown, // in power-down
	output logic selfRefreshing // in self refresh
);
	core_state_t s_reg, s_next;
	logic pushValid;
	write_item_t pushItem;

	function automatic cmd_t decodeCmd(input cmd_pins_t p);
		return cmd_t'({~p.rasN & ~p.casN, ~p.casN & p.rasN | ~p.rasN & p.casN & ~p.weN,
			~p.weN ^ (~p.rasN & ~p.casN) | (~p.rasN & p.casN & p.weN)});
	endfunction

	// code table written out so the encoding cannot drift from the pins
	function automatic cmd_t pinsToCmd(input cmd_pins_t p);
		unique case ({p.rasN, p.casN, p.weN})
			3'h0: return CMD_MRS;
			3'h1: return CMD_REF;
			3'h2: return CMD_PRE;
			3'h3: return CMD_ACT;
			3'h4: return CMD_WRITE;
			3'h5: return CMD_READ;
			3'h6: return CMD_BST;
			3'h7: return CMD_NOP;
		endcase
	endfunction

	function automatic logic [LEN_W-1:0] burstLen(input logic [2:0] code);
		unique case (code)
			BL_1: return LEN_1;
			BL_2: return LEN_2;
			BL_4: return LEN_4;
			BL_8: return LEN_8;
			BL_PAGE: return LEN_PAGE;
			default: return LEN_1;
		endcase
	endfunction

	function automatic logic [COL_W-1:0] burstCol(input logic [COL_W-1:0] start,
			input logic [LEN_W-1:0] idx, input logic [ROW_W-1:0] mode);
		logic [COL_W-1:0] grp;
		logic [COL_W-1:0] low;
		unique case (mode[MODE_BL_LSB +: 3])
			BL_2: grp = GROUP_2;
			BL_4: grp = GROUP_4;
			BL_8: grp = GROUP_8;
			BL_PAGE: grp = GROUP_PAGE;
			default: grp = '0;
		endcase
		// full page has no interleave order, so it always counts up
		if (mode[MODE_ORDER_BIT] && mode[MODE_BL_LSB +: 3] != BL_PAGE) begin
			low = start ^ idx[COL_W-1:0];
		end else begin
			low = start + idx[COL_W-1:0];
		end
		return (start & ~grp) | (low & grp);
	endfunction

	always_comb begin
		cmd_t cmd;
		logic cmdValid;
		logic busy;
		logic kill;
		logic issue;
		logic issueWrite;
		array_addr_t issueAddr;
		logic [LEN_W-1:0] len;
		logic [1:0] cmdBank;
		cmd = pinsToCmd(cmdPins);
		cmdBank = bankSelect;
		cmdValid = cke && s_reg.ckePrev && !cmdPins.csN && s_reg.pwr == PWR_RUN;
		busy = s_reg.burst.active || (s_reg.rdValid != '0);
		kill = 1'b0;
		issue = 1'b0;
		issueWrite = 1'b0;
		issueAddr = '0;
		len = '0;
		pushValid = 1'b0;
		pushItem = '0;
		s_next = s_reg;
		s_next.ckePrev = cke;
		s_next.refreshPulse = 1'b0;
		unique case (s_reg.pwr)
			PWR_SELF: begin
				s_next.dqOe = '0;
				if (s_reg.selfTimer == SELF_TIMER_LAST) begin
					s_next.selfTimer = '0;
					s_next.refreshPulse = 1'b1;
					s_next.refreshRow = s_reg.refreshRow + 12'h001;
				end else begin
					s_next.selfTimer = s_reg.selfTimer + 12'h001;
				end
				if (cke) begin
					s_next.pwr = PWR_RUN;
				end
			end
			PWR_DOWN: begin
				s_next.dqOe = '0;
				if (cke) begin
					s_next.pwr = PWR_RUN;
				end
			end
			PWR_RUN: begin
				if (!cke && busy) begin
					// frozen: everything but the clock-enable history and the refresh pulse holds
					s_next.ckePrev = cke;
				end else if (!cke) begin
					s_next.dqOe = '0;
					s_next.selfTimer = '0;
					if (s_reg.ckePrev && !cmdPins.csN && cmd == CMD_REF &&
							s_reg.bankActive == '0) begin
						s_next.pwr = PWR_SELF;
					end else begin
						s_next.pwr = PWR_DOWN;
					end
				end else begin
					s_next.dqmD = {upperByteMask, lowerByteMask};
					s_next.dqOut = s_reg.rdData[0];
					s_next.dqOe = s_reg.rdValid[0] ? ~s_reg.dqmD : 2'h0;
					s_next.rdValid = {1'b0, s_reg.rdValid[1]};
					s_next.rdData = {s_reg.rdData[1], s_reg.rdData[1]};
					if (cmdValid && s_reg.burst.active) begin
						unique case (cmd)
							CMD_READ, CMD_WRITE: kill = 1'b1;
							CMD_BST: kill = s_reg.burst.len == LEN_PAGE;
							CMD_PRE: kill = addr[AP_BIT] ||
								cmdBank == s_reg.burst.bank;
							default: kill = 1'b0;
						endcase
					end
					if (kill) begin
						s_next.burst.active = 1'b0;
					end else if (s_reg.burst.active) begin
						issue = 1'b1;
						issueWrite = s_reg.burst.isWrite;
						issueAddr.bank = s_reg.burst.bank;
						issueAddr.row = s_reg.burst.row;
						issueAddr.col = burstCol(s_reg.burst.start, s_reg.burst.idx,
							s_reg.mode);
						s_next.burst.idx = s_reg.burst.idx + 9'h001;
						if (s_reg.burst.len != LEN_PAGE &&
								s_reg.burst.idx == s_reg.burst.len - 9'h001) begin
							s_next.burst.active = 1'b0;
							if (s_reg.burst.autoPre) begin
								s_next.bankActive[s_reg.burst.bank] = 1'b0;
							end
						end
					end
					if (cmdValid) begin
						unique case (cmd)
							CMD_ACT: begin
								s_next.bankActive[cmdBank] = 1'b1;
								s_next.bankRow[cmdBank] = addr;
							end
							CMD_PRE: begin
								if (addr[AP_BIT]) begin
									s_next.bankActive = '0;
								end else begin
									s_next.bankActive[cmdBank] = 1'b0;
								end
							end
							CMD_READ, CMD_WRITE: begin
								if (s_reg.bankActive[cmdBank]) begin
									len = burstLen(s_reg.mode[MODE_BL_LSB +: 3]);
									if (cmd == CMD_WRITE && s_reg.mode[MODE_WMODE_BIT]) begin
										len = LEN_1;
									end
									issue = 1'b1;
									issueWrite = cmd == CMD_WRITE;
									issueAddr.bank = cmdBank;
									issueAddr.row = s_reg.bankRow[cmdBank];
									issueAddr.col = addr[COL_W-1:0];
									s_next.burst.active = len != LEN_1;
									s_next.burst.isWrite = cmd == CMD_WRITE;
									s_next.burst.autoPre = addr[AP_BIT];
									s_next.burst.bank = cmdBank;
									s_next.burst.row = s_reg.bankRow[cmdBank];
									s_next.burst.start = addr[COL_W-1:0];
									s_next.burst.idx = 9'h001;
									s_next.burst.len = len;
									if (len == LEN_1 && addr[AP_BIT]) begin
										s_next.bankActive[cmdBank] = 1'b0;
									end
								end
							end
							CMD_MRS: begin
								if (s_reg.bankActive == '0) begin
									s_next.mode = addr;
								end
							end
							CMD_REF: begin
								if (s_reg.bankActive == '0) begin
									s_next.refreshPulse = 1'b1;
									s_next.refreshRow = s_reg.refreshRow + 12'h001;
								end
							end
							default: begin
							end
						endcase
					end
					if (issue && issueWrite) begin
						pushItem.addr = issueAddr;
						pushItem.mask = {upperByteMask, lowerByteMask};
						pushItem.data = dqIn;
						pushValid = pushItem.mask != MASK_ALL;
					end else if (issue) begin
						// latency three parks the word one stage further back
						if (s_reg.mode[MODE_CL_LSB +: 3] == CL_3) begin
							s_next.rdValid[1] = 1'b1;
							s_next.rdData[1] = arrayRdData;
						end else begin
							s_next.rdValid[0] = 1'b1;
							s_next.rdData[0] = arrayRdData;
						end
					end
				end
			end
			default: s_next.pwr = PWR_RUN;
		endcase
		arrayRdAddr = issueAddr;
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			s_reg <= '0;
		end else begin
			s_reg <= s_next;
		end
	end

	// a full queue drops words; writeQueueReady tells the array side to hurry
	sdram_write_fifo #(
		.WIDTH(WRITE_ITEM_W),
		.DEPTH(FIFO_DEPTH)
	) writeQueue (
		.clock(clock),
		.rst(rst),
		.inValid(pushValid),
		.inReady(writeQueueReady),
		.inData(pushItem),
		.outValid(arrayWrValid),
		.outReady(arrayWrReady),
		.outData(arrayWrItem)
	);

	assign dqOut = s_reg.dqOut;
	assign dqOe = s_reg.dqOe;
	assign refreshPulse = s_reg.refreshPulse;
	assign refreshRow = s_reg.refreshRow;
	assign bankActive = s_reg.bankActive;
	assign poweredDown = s_reg.pwr == PWR_DOWN;
	assign selfRefreshing = s_reg.pwr == PWR_SELF;

	sequence readCl2Issue;
		cke && s_reg.ckePrev && !cmdPins.csN && pinsToCmd(cmdPins) == CMD_READ &&
		s_reg.pwr == PWR_RUN && s_reg.bankActive[bankSelect] &&
		s_reg.mode[MODE_CL_LSB +: 3] != CL_3;
	endsequence

	sequence quietMask;
		cke && {upperByteMask, lowerByteMask} == 2'h0;
	endsequence

	AST_SELF_QUIET: assert property (@(posedge clock) disable iff (rst)
		selfRefreshing |-> dqOe == 2'h0 && !pushValid)
		else $error("buffers active in self refresh");

	AST_SUSPEND_HOLD: assert property (@(posedge clock) disable iff (rst)
		s_reg.pwr == PWR_RUN && !cke && s_reg.burst.active |=>
		$stable(s_reg.burst) && $stable(dqOut))
		else $error("burst moved while clock suspended");

	AST_PWRDN_ENTRY: assert property (@(posedge clock) disable iff (rst)
		s_reg.pwr == PWR_RUN && !cke && !s_reg.burst.active && s_reg.rdValid == 2'h0 &&
		(cmdPins.csN || pinsToCmd(cmdPins) == CMD_NOP) |=> poweredDown ##0 dqOe == 2'h0)
		else $error("idle low clock enable missed power-down");

	AST_WAKE: assert property (@(posedge clock) disable iff (rst)
		(poweredDown || selfRefreshing) && cke |=> !poweredDown && !selfRefreshing)
		else $error("raised clock enable did not wake");

	AST_READ_LAT2: assert property (@(posedge clock) disable iff (rst)
		readCl2Issue ##0 quietMask ##1 quietMask |=> dqOe == 2'h3)
		else $error("latency two read word not driven");

	AST_WRITE_PUSH: assert property (@(posedge clock) disable iff (rst)
		cke && s_reg.pwr == PWR_RUN && s_reg.burst.active && s_reg.burst.isWrite &&
		(cmdPins.csN || pinsToCmd(cmdPins) == CMD_NOP) &&
		{upperByteMask, lowerByteMask} != MASK_ALL |-> pushValid && pushItem.data == dqIn)
		else $error("burst write word not latched");

	AST_AUTOPRE_IDLE: assert property (@(posedge clock) disable iff (rst)
		cke && s_reg.pwr == PWR_RUN && s_reg.burst.active && s_reg.burst.autoPre &&
		s_reg.burst.len != LEN_PAGE && s_reg.burst.idx == s_reg.burst.len - 9'h001 &&
		(cmdPins.csN || pinsToCmd(cmdPins) == CMD_NOP) |=> !bankActive[$past(s_reg.burst.bank)])
		else $error("auto-precharge left bank open");

	AST_PRE_ALL: assert property (@(posedge clock) disable iff (rst)
		cke && s_reg.ckePrev && s_reg.pwr == PWR_RUN && !cmdPins.csN &&
		pinsToCmd(cmdPins) == CMD_PRE && addr[AP_BIT] |=> bankActive == 4'h0)
		else $error("precharge-all left a bank open");

	AST_SINGLE_WRITE: assert property (@(posedge clock) disable iff (rst)
		cke && s_reg.ckePrev && s_reg.pwr == PWR_RUN && !cmdPins.csN &&
		pinsToCmd(cmdPins) == CMD_WRITE && s_reg.mode[MODE_WMODE_BIT] |=>
		!s_reg.burst.active)
		else $error("single-write mode ran a burst");

	AST_STOP_WRITE: assert property (@(posedge clock) disable iff (rst)
		cke && s_reg.ckePrev && s_reg.pwr == PWR_RUN && !cmdPins.csN &&
		pinsToCmd(cmdPins) == CMD_BST && s_reg.burst.len == LEN_PAGE |-> !pushValid
		##1 !s_reg.burst.active)
		else $error("burst stop did not end full page burst");

	AST_MODE_HOLD: assert property (@(posedge clock) disable iff (rst)
		!(cke && !cmdPins.csN && pinsToCmd(cmdPins) == CMD_MRS) |=> $stable(s_reg.mode))
		else $error("mode word changed without mode set");
endmodule

// ==== core/sdram_pkg.sv ====
// constants, types and state layout shared by the sdram command core
package sdram_pkg;
	localparam int DATA_W = 16;
	localparam int ROW_W = 12;
	localparam int COL_W = 8;
	localparam int BANKS = 4;
	localparam int LEN_W = 9;
	localparam int MODE_BL_LSB = 0;
	localparam int MODE_ORDER_BIT = 3;
	localparam int MODE_CL_LSB = 4;
	localparam int MODE_WMODE_BIT = 9;
	localparam int AP_BIT = 10;
	localparam logic [2:0] BL_1 = 3'h0;
	localparam logic [2:0] BL_2 = 3'h1;
	localparam logic [2:0] BL_4 = 3'h2;
	localparam logic [2:0] BL_8 = 3'h3;
	localparam logic [2:0] BL_PAGE = 3'h7;
	localparam logic [2:0] CL_3 = 3'h3;
	localparam logic [LEN_W-1:0] LEN_1 = 9'h001;
	localparam logic [LEN_W-1:0] LEN_2 = 9'h002;
	localparam logic [LEN_W-1:0] LEN_4 = 9'h004;
	localparam logic [LEN_W-1:0] LEN_8 = 9'h008;
	localparam logic [LEN_W-1:0] LEN_PAGE = 9'h100;
	localparam logic [COL_W-1:0] GROUP_2 = 8'h01;
	localparam logic [COL_W-1:0] GROUP_4 = 8'h03;
	localparam logic [COL_W-1:0] GROUP_8 = 8'h07;
	localparam logic [COL_W-1:0] GROUP_PAGE = 8'hFF;
	localparam logic [1:0] MASK_ALL = 2'h3;
	localparam int REFRESH_WINDOW_MS = 64;
	localparam int REFRESH_ROWS = 4096;
	localparam int CLOCK_PERIOD_PS = 4000;
	localparam int SELF_REFRESH_CYCLES =
		int'(longint'(REFRESH_WINDOW_MS) * 64'd1000000000 / REFRESH_ROWS / CLOCK_PERIOD_PS);
	localparam logic [11:0] SELF_TIMER_LAST = 12'(SELF_REFRESH_CYCLES - 1);
	localparam int FIFO_DEPTH = 8;

	typedef enum logic [2:0] {
		CMD_NOP = 3'b000,
		CMD_ACT = 3'b001,
		CMD_PRE = 3'b010,
		CMD_WRITE = 3'b011,
		CMD_READ = 3'b100,
		CMD_MRS = 3'b101,
		CMD_REF = 3'b110,
		CMD_BST = 3'b111
	} cmd_t;

	typedef enum logic [1:0] {
		PWR_RUN = 2'b00,
		PWR_DOWN = 2'b01,
		PWR_SELF = 2'b10
	} pwr_t;

	typedef struct packed {
		logic csN;
		logic rasN;
		logic casN;
		logic weN;
	} cmd_pins_t;

	typedef struct packed {
		logic [1:0] bank;
		logic [ROW_W-1:0] row;
		logic [COL_W-1:0] col;
	} array_addr_t;

	typedef struct packed {
		array_addr_t addr;
		logic [1:0] mask;
		logic [DATA_W-1:0] data;
	} write_item_t;

	localparam int WRITE_ITEM_W = $bits(write_item_t);

	typedef struct packed {
		logic active;
		logic isWrite;
		logic autoPre;
		logic [1:0] bank;
		logic [ROW_W-1:0] row;
		logic [COL_W-1:0] start;
		logic [LEN_W-1:0] idx;
		logic [LEN_W-1:0] len;
	} burst_t;

	typedef struct packed {
		pwr_t pwr;
		logic ckePrev;
		logic [ROW_W-1:0] mode;
		logic [BANKS-1:0] bankActive;
		logic [BANKS-1:0][ROW_W-1:0] bankRow;
		burst_t burst;
		logic [1:0] rdValid;
		logic [1:0][DATA_W-1:0] rdData;
		logic [1:0] dqmD;
		logic [DATA_W-1:0] dqOut;
		logic [1:0] dqOe;
		logic [ROW_W-1:0] refreshRow;
		logic refreshPulse;
		logic [11:0] selfTimer;
	} core_state_t;
endpackage

// ==== core/sdram_write_fifo.sv ====
// write-word queue between the pin side and the cell array port
`timescale 1ns/1ps
module sdram_write_fifo import sdram_pkg::*; #(
	parameter int WIDTH = WRITE_ITEM_W,
	parameter int DEPTH = FIFO_DEPTH
) (
	input wire logic clock, // system clock
	input wire logic rst, // async reset, high
	input wire logic inValid, // word offered
	output logic inReady, // room for a word
	input wire logic [WIDTH-1:0] inData, // word in
	output logic outValid, // word waiting
	input wire logic outReady, // sink takes word
	output logic [WIDTH-1:0] outData // head word
);
	localparam int PW = $clog2(DEPTH);
	localparam logic [PW:0] FULL_COUNT = (PW+1)'(DEPTH);
	localparam logic [PW-1:0] LAST_PTR = PW'(DEPTH - 1);

	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] mem;
		logic [PW-1:0] wr;
		logic [PW-1:0] rd;
		logic [PW:0] count;
	} fifo_state_t;

	fifo_state_t s_reg, s_next;

	function automatic logic [PW-1:0] nextPtr(input logic [PW-1:0] p);
		return (p == LAST_PTR) ? '0 : p + PW'(1);
	endfunction

	assign inReady = s_reg.count != FULL_COUNT;
	assign outValid = s_reg.count != '0;
	assign outData = s_reg.mem[s_reg.rd];

	always_comb begin
		logic push;
		logic pop;
		push = inValid && inReady;
		pop = outValid && outReady;
		s_next = s_reg;
		if (push) begin
			s_next.mem[s_reg.wr] = inData;
			s_next.wr = nextPtr(s_reg.wr);
		end
		if (pop) begin
			s_next.rd = nextPtr(s_reg.rd);
		end
		if (push && !pop) begin
			s_next.count = s_reg.count + (PW+1)'(1);
		end else if (pop && !push) begin
			s_next.count = s_reg.count - (PW+1)'(1);
		end
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			s_reg <= '0;
		end else begin
			s_reg <= s_next;
		end
	end
endmodule

// ==== tb/sdram_array_model.sv ====
// stand-in for the cell array behind the core: read words and a stallable write sink
`timescale 1ns/1ps
module sdram_array_model import sdram_pkg::*; (
	input wire array_addr_t rdAddr, // read address from core
	output logic [DATA_W-1:0] rdData, // read word, same cycle
	input wire logic hold, // stall the write sink
	output logic wrReady // sink takes head word
);
	// each word carries its own place, so a wrong column order shows at once
	assign rdData = {rdAddr.bank, rdAddr.row[5:0], rdAddr.col};
	assign wrReady = !hold;
endmodule

// ==== tb/testbench.sv ====
// self-checking bench for the sdram command core
`timescale 1ns/1ps
`define CHK(what, e, a) begin \
	check_count++; \
	if ((a) !== (e)) begin \
		mismatches++; \
		$display("CHECK FAILED %s expected %h seen %h", what, e, a); \
	end \
end
module testbench import sdram_pkg::*; ();
	localparam logic [2:0] P_ACT = 3'h3;
	localparam logic [2:0] P_PRE = 3'h2;
	localparam logic [2:0] P_WR = 3'h4;
	localparam logic [2:0] P_RD = 3'h5;
	localparam logic [2:0] P_MRS = 3'h0;
	localparam logic [2:0] P_REF = 3'h1;
	localparam logic [2:0] P_BST = 3'h6;
	localparam logic [ROW_W-1:0] ROW = 12'h0A5;
	logic clock = 1'b0;
	logic rst = 1'b1;
	logic cke = 1'b1;
	logic lowerByteMask = 1'b0;
	logic upperByteMask = 1'b0;
	logic hold = 1'b1;
	cmd_pins_t cmdPins = 4'hF;
	logic [1:0] bankSelect = 2'h0;
	logic [ROW_W-1:0] addr = 12'h000;
	logic [DATA_W-1:0] dqIn = 16'h0000;
	logic [DATA_W-1:0] dqOut, arrayRdData;
	logic [1:0] dqOe;
	array_addr_t arrayRdAddr;
	write_item_t arrayWrItem, e;
	logic arrayWrValid, arrayWrReady, writeQueueReady, refreshPulse, poweredDown, selfRefreshing;
	logic [ROW_W-1:0] refreshRow, r0;
	logic [BANKS-1:0] bankActive;
	int mismatches = 0;
	int check_count = 0;
	int n;
	write_item_t expq[$];

	always #2 clock = ~clock;

	sdram_command_burst_core DUT (.clock(clock), .rst(rst), .cke(cke), .cmdPins(cmdPins),
		.bankSelect(bankSelect), .addr(addr), .lowerByteMask(lowerByteMask),
		.upperByteMask(upperByteMask), .dqIn(dqIn), .dqOut(dqOut), .dqOe(dqOe),
		.arrayRdAddr(arrayRdAddr), .arrayRdData(arrayRdData), .arrayWrValid(arrayWrValid),
		.arrayWrItem(arrayWrItem), .arrayWrReady(arrayWrReady),
		.writeQueueReady(writeQueueReady), .refreshPulse(refreshPulse),
		.refreshRow(refreshRow), .bankActive(bankActive), .poweredDown(poweredDown),
		.selfRefreshing(selfRefreshing));
	sdram_array_model cells (.rdAddr(arrayRdAddr), .rdData(arrayRdData), .hold(hold),
		.wrReady(arrayWrReady));

	task automatic end_of_test();
		$display("checks %0d mismatches %0d", check_count, mismatches);
		if (mismatches == 0 && check_count > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	task automatic done(input string name);
		$display("test %s ended", name);
	endtask

	function automatic logic [7:0] seq(input logic [7:0] c, input int i, input int bl);
		return (c & ~8'(bl - 1)) | (8'(int'(c) + i) & 8'(bl - 1));
	endfunction

	// pins change after one edge and are taken at the next
	task automatic cmd(input logic [2:0] p, input logic [1:0] b = 2'h0,
			input logic [11:0] a = 12'h000, input logic [1:0] m = 2'h0,
			input logic [15:0] d = 16'h0000);
		@(posedge clock);
		cmdPins <= {1'b0, p};
		bankSelect <= b;
		addr <= a;
		{upperByteMask, lowerByteMask} <= m;
		dqIn <= d;
		@(posedge clock);
		cmdPins <= 4'h7;
	endtask

	task automatic mrs(input logic [2:0] bl, input logic il, input logic [2:0] cl, input logic wm);
		cmd(P_MRS, 2'h0, {2'h0, wm, 2'h0, cl, il, bl});
	endtask

	task automatic act(input logic [1:0] b);
		cmd(P_ACT, b, ROW);
		repeat (2) @(posedge clock);
	endtask

	task automatic rd(input logic [1:0] b, input logic [7:0] c, input int bl, input int cl,
			input logic il, input logic ap, input logic [1:0] m);
		logic [7:0] col;
		cmd(P_RD, b, {1'b0, ap, 2'h0, c}, m);
		{upperByteMask, lowerByteMask} <= 2'h0;
		for (int k = 1; k <= cl; k++) begin
			if (k > 1)
				@(posedge clock);
			#1;
			`CHK("read oe", (k == cl) ? ~m : 2'h0, dqOe)
		end
		for (int i = 0; i < bl; i++) begin
			if (i > 0) begin
				@(posedge clock);
				#1;
				`CHK("read oe", 2'h3, dqOe)
			end
			col = il ? c ^ 8'(i) : seq(c, i, bl);
			if (i > 0 || m == 2'h0)
				`CHK("read data", {b, ROW[5:0], col}, dqOut)
		end
		@(posedge clock);
		#1;
		`CHK("read end", 2'h0, dqOe)
		`CHK("bank open", !ap, bankActive[b])
	endtask

	task automatic wr(input logic [1:0] b, input logic [7:0] c, input int bl, input int nw,
			input int take, input logic ap = 1'b0);
		for (int i = 0; i < take; i++) begin
			e.addr = '{b, ROW, seq(c, i, bl)};
			e.mask = (i == 2) ? 2'h1 : 2'h0;
			e.data = 16'hA000 + 16'(i);
			expq.push_back(e);
		end
		cmd(P_WR, b, {1'b0, ap, 2'h0, c}, 2'h0, 16'hA000);
		for (int i = 1; i < nw; i++) begin
			dqIn <= 16'hA000 + 16'(i);
			{upperByteMask, lowerByteMask} <= (i == 2) ? 2'h1 : 2'h0;
			@(posedge clock);
		end
		// data lines idle at the inverse so a stale word cannot pass
		dqIn <= ~dqIn;
		{upperByteMask, lowerByteMask} <= 2'h0;
	endtask

	task automatic drain();
		@(posedge clock);
		hold <= 1'b0;
		repeat (20) begin
			@(negedge clock);
			if (arrayWrValid === 1'b1 && expq.size() > 0) begin
				e = expq.pop_front();
				`CHK("write item", e, arrayWrItem)
			end else
				`CHK("write valid", 1'b0, arrayWrValid)
		end
		`CHK("write left", 0, expq.size())
		@(posedge clock);
		hold <= 1'b1;
	endtask

	initial begin
		repeat (12) @(posedge clock);
		rst <= 1'b0;
		repeat (2) @(posedge clock);
		#1;
		`CHK("reset", {2'h0, 4'h0, 2'h2, 12'h000, 2'h0}, {dqOe, bankActive, writeQueueReady, arrayWrValid, refreshRow, poweredDown, selfRefreshing})
		done("reset");
		for (int j = 0; j < 4; j++) begin
			mrs(3'(j), 1'b0, 3'h2, 1'b0);
			act(2'h0);
			rd(2'h0, 8'h05, 1 << j, 2, 1'b0, j == 3, 2'(j == 1));
			cmd(P_PRE);
		end
		done("burst lengths");
		mrs(BL_8, 1'b1, CL_3, 1'b0);
		act(2'h1);
		rd(2'h1, 8'h0D, 8, 3, 1'b1, 1'b0, 2'h0);
		rd(2'h1, 8'h02, 8, 3, 1'b1, 1'b0, 2'h0);
		done("interleave");
		act(2'h2);
		#1;
		`CHK("banks", 4'h6, bankActive)
		cmd(P_PRE, 2'h0, 12'h400);
		#1;
		`CHK("banks", 4'h0, bankActive)
		done("precharge");
		r0 = refreshRow;
		cmd(P_REF);
		#1;
		`CHK("refresh pulse", 1'b1, refreshPulse)
		repeat (3) @(posedge clock);
		#1;
		`CHK("refresh row", 12'(r0 + 1), refreshRow)
		act(2'h3);
		cmd(P_REF);
		#1;
		`CHK("refresh pulse", 1'b0, refreshPulse)
		repeat (3) @(posedge clock);
		#1;
		`CHK("refresh refused", 12'(r0 + 1), refreshRow)
		cmd(P_PRE, 2'h3);
		done("refresh");
		@(posedge clock);
		cke <= 1'b0;
		repeat (3) @(posedge clock);
		#1;
		`CHK("power down", 1'b1, poweredDown)
		@(posedge clock);
		cke <= 1'b1;
		repeat (2) @(posedge clock);
		#1;
		`CHK("power up", 1'b0, poweredDown)
		@(posedge clock);
		cmdPins <= {1'b0, P_REF};
		cke <= 1'b0;
		@(posedge clock);
		cmdPins <= 4'h7;
		repeat (2) @(posedge clock);
		#1;
		`CHK("self refresh", 1'b1, selfRefreshing)
		r0 = refreshRow;
		repeat (SELF_REFRESH_CYCLES + 4) @(posedge clock);
		#1;
		`CHK("self row", 12'(r0 + 1), refreshRow)
		@(posedge clock);
		cke <= 1'b1;
		repeat (20) @(posedge clock);
		#1;
		`CHK("self exit", 1'b0, selfRefreshing)
		done("power");
		mrs(BL_8, 1'b0, 3'h2, 1'b0);
		act(2'h0);
		wr(2'h0, 8'h06, 8, 8, 8);
		#1;
		`CHK("queue full", 2'h1, {writeQueueReady, arrayWrValid})
		wr(2'h0, 8'h00, 8, 8, 0);
		drain();
		cmd(P_PRE);
		mrs(BL_4, 1'b0, 3'h2, 1'b1);
		act(2'h0);
		wr(2'h0, 8'h01, 4, 4, 1, 1'b1);
		#1;
		`CHK("write auto close", 1'b0, bankActive[0])
		drain();
		done("write queue");
		cmd(P_PRE);
		mrs(BL_PAGE, 1'b0, CL_3, 1'b0);
		act(2'h0);
		cmd(P_RD);
		repeat (6) @(posedge clock);
		cmd(P_PRE);
		n = 0;
		repeat (6) begin
			#1;
			if (dqOe === 2'h3)
				n++;
			@(posedge clock);
		end
		`CHK("words after cut", 2, n)
		done("page cut");
		act(2'h0);
		// page write wraps past the last column, then a stop ends it at once
		wr(2'h0, 8'hFE, 256, 4, 4);
		cmdPins <= {1'b0, P_BST};
		@(posedge clock);
		cmdPins <= 4'h7;
		drain();
		cmd(P_PRE);
		done("page stop");
		mrs(BL_4, 1'b0, 3'h2, 1'b0);
		act(2'h0);
		cmd(P_RD, 2'h0, 12'h004);
		cke <= 1'b0;
		@(posedge clock);
		cke <= 1'b1;
		#1;
		`CHK("suspend hold", 2'h0, dqOe)
		@(posedge clock);
		#1;
		`CHK("suspend word", {2'h0, ROW[5:0], 8'h04}, dqOut)
		`CHK("suspend oe", 2'h3, dqOe)
		repeat (4) @(posedge clock);
		done("suspend");
		end_of_test();
	end

	// whole run is near 4200 cycles
	initial begin
		repeat (30000) @(posedge clock);
		mismatches++;
		end_of_test();
	end
endmodule
